/* File: csam_monitor.sv */
// Configuration and sensor alert monitor with self-test shutdown.
// Assumes readings and output-block pulses arrive on clk_in; the disconnect
// level comes from a pin. Also holds the range checker it instantiates.
`timescale 1ns/1ps
`default_nettype none

module csam_range
   import csam_pkg::*;
#(
   parameter logic [15:0] LO = 16'h0000,
   parameter logic [15:0] HI = 16'hffff
) (
   input wire logic clk_in, // System clock.
   input wire logic rst_in, // Synchronous reset, active high.
   input wire logic [15:0] value_in, // Sensor reading.
   output logic oor_out // Reading outside its functional range.
);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         oor_out <= 1'b0;
      end else begin
         oor_out <= (value_in < LO) || (value_in > HI);
      end
   end

   AST_RANGE: assert property (@(posedge clk_in) disable iff (rst_in)
      (value_in < LO || value_in > HI) |=> oor_out)
      else $error("Out-of-range reading not flagged.");

endmodule

////////////////////////////////////////////////////////////////////////////////

// Operation
// - Flag setpoint updates older than timeout
// - Timeout is largest gap between updates
// - Each alert reported only when enabled
// - Enabled trigger plus timeout, travel or port A alert forces shutdown
// - Timeout shutdown auto-recovers when recovery set
// - Else hold until reset or host mode
// - Stay out of service while cause persists
// - Travel and port A recovery polarity inverted
// - Defaults alert holds until leaving out-of-service
// - Host-writable alert key for grouping
// - Travel alert on range fault or disconnect
// - Travel alert may trigger shutdown
// - Port A range alert may trigger shutdown
// - Port B and supply gated by enable only
// - Fallback alert when pressure control engaged
// - Temperature alert on range fault
module csam_monitor
   import csam_pkg::*;
(
   input wire logic clk_in, // System clock, 200 MHz.
   input wire logic rst_in, // Synchronous reset, active high.
   input wire logic [7:0] addr_in, // Register byte address.
   input wire logic [31:0] wdata_in, // Register write data.
   input wire logic wr_in, // Write strobe.
   input wire logic rd_in, // Read strobe.
   output logic [31:0] rdata_out, // Read data, one cycle after rd_in.
   input wire logic setpoint_update_in, // Output block wrote the setpoint.
   input wire logic restart_defaults_in, // Resource block restarted with defaults.
   input wire logic fallback_in, // Control fell back to pressure.
   input wire logic travel_disconnect_in, // Travel sensor missing, from a pin.
   input wire logic [15:0] travel_in, // Travel reading.
   input wire logic [15:0] press_a_in, // Port A pressure reading.
   input wire logic [15:0] press_b_in, // Port B pressure reading.
   input wire logic [15:0] supply_in, // Supply pressure reading.
   input wire logic [15:0] temp_in, // Temperature reading.
   output logic [7:0] alert_active_out, // Enabled, active alerts.
   output logic [1:0] actual_mode_out, // Transducer actual mode.
   output logic zero_power_out, // Drive valve to zero power, control stopped.
   output logic [KEY_W-1:0] alert_key_out, // Plant unit number.
   output logic irq_out // Unmasked status bit set.
);

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers written by software.

   logic [7:0] alert_en;
   logic [7:0] trig_en;
   logic [7:0] rec_en;
   logic [7:0] irq_mask;
   logic [TMO_W-1:0] tmo_limit;
   logic [1:0] target_mode;
   logic [7:0] irq_status;
   logic [7:0] raw;
   logic [7:0] shut_vec;
   logic shut_cond;
   logic need_manual;
   logic host_release;
   csam_mstate_t state;
   csam_mstate_t next_state;
   logic [1:0] next_actual;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         alert_en <= ENABLE_RESET;
         trig_en <= TRIGGER_RESET;
         rec_en <= RECOVERY_RESET;
         irq_mask <= MASK_RESET;
         tmo_limit <= TIMEOUT_RESET;
      end else if (wr_in) begin
         if (hit(addr_in, REG_ENABLE)) begin
            alert_en <= wdata_in[7:0];
         end
         if (hit(addr_in, REG_TRIGGER)) begin
            trig_en <= wdata_in[7:0];
         end
         if (hit(addr_in, REG_RECOVERY)) begin
            rec_en <= wdata_in[7:0];
         end
         if (hit(addr_in, REG_MASK)) begin
            irq_mask <= wdata_in[7:0];
         end
         if (hit(addr_in, REG_TIMEOUT)) begin
            tmo_limit <= wdata_in[TMO_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         alert_key_out <= KEY_RESET;
      end else if (wr_in && hit(addr_in, REG_KEY)) begin
         alert_key_out <= wdata_in[KEY_W-1:0];
      end
   end

   // Only manual or auto releases a held shutdown; the target stores any code.
   logic target_wr_ok;
   assign target_wr_ok = wr_in && hit(addr_in, REG_TARGET)
      && (wdata_in[1:0] == MODE_MAN || wdata_in[1:0] == MODE_AUTO);
   assign host_release = target_wr_ok && !shut_cond;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         target_mode <= TARGET_RESET;
      end else if (wr_in && hit(addr_in, REG_TARGET)) begin
         target_mode <= wdata_in[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Setpoint update timeout, counted in ticks.

   logic [7:0] tick_cnt;
   logic tick;
   logic [TMO_W-1:0] tmo_cnt;

   always_ff @(posedge clk_in) begin
      if (rst_in || setpoint_update_in || tick_cnt == TICK_LAST) begin
         tick_cnt <= 8'h00;
      end else begin
         tick_cnt <= tick_cnt + 8'h01;
      end
   end
   assign tick = (tick_cnt == TICK_LAST);

   // The count saturates so a long outage never wraps back below the limit.
   always_ff @(posedge clk_in) begin
      if (rst_in || setpoint_update_in) begin
         tmo_cnt <= '0;
      end else if (tick && tmo_cnt != '1) begin
         tmo_cnt <= tmo_cnt + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sensor checks.

   logic disconnect_sync;
   logic [15:0] sens [NUM_SENSORS];
   logic [NUM_SENSORS-1:0] oor;

   csam_sync u_disc (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .async_in(travel_disconnect_in),
      .sync_out(disconnect_sync)
   );

   assign sens[0] = travel_in;
   assign sens[1] = press_a_in;
   assign sens[2] = press_b_in;
   assign sens[3] = supply_in;
   assign sens[4] = temp_in;

   for (genvar g = 0; g < NUM_SENSORS; g++) begin : g_range
      csam_range #(
         .LO(SENS_LO[g]),
         .HI(SENS_HI[g])
      ) u_range (
         .clk_in(clk_in),
         .rst_in(rst_in),
         .value_in(sens[g]),
         .oor_out(oor[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Raw alert conditions.

   logic defaults_flag;
   logic leave_oos;
   assign leave_oos = (actual_mode_out == MODE_OOS) && (next_actual != MODE_OOS);

   // A restart in the same cycle as leaving out of service keeps the flag.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         defaults_flag <= 1'b0;
      end else if (restart_defaults_in) begin
         defaults_flag <= 1'b1;
      end else if (leave_oos) begin
         defaults_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         raw <= 8'h00;
      end else begin
         raw[ALT_TIMEOUT] <= (tmo_cnt > tmo_limit);
         raw[ALT_DEFAULTS] <= defaults_flag;
         raw[ALT_TRAVEL] <= oor[0] || disconnect_sync;
         raw[ALT_PORT_A] <= oor[1];
         raw[ALT_PORT_B] <= oor[2];
         raw[ALT_SUPPLY] <= oor[3];
         raw[ALT_FALLBACK] <= fallback_in;
         raw[ALT_TEMP] <= oor[4];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         alert_active_out <= 8'h00;
      end else begin
         alert_active_out <= raw & alert_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Self-test shutdown.

   // Port B and supply are outside SHUT_CAPABLE, so only their enable matters.
   assign shut_vec = alert_active_out & trig_en & SHUT_CAPABLE;
   assign shut_cond = |shut_vec;

   logic [7:0] manual_vec;
   assign manual_vec = shut_vec & ~(rec_en ^ REC_INVERTED);

   always_comb begin
      next_state = state;
      case (state)
         MS_RUN: begin
            if (shut_cond) begin
               next_state = MS_SHUT;
            end
         end
         MS_SHUT: begin
            if (!shut_cond && (!need_manual || host_release)) begin
               next_state = MS_RUN;
            end
         end
         default: begin
            next_state = MS_RUN;
         end
      endcase
   end

   assign next_actual = (next_state == MS_SHUT) ? MODE_OOS : target_mode;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= MS_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Any cause without automatic recovery keeps the whole shutdown manual.
   always_ff @(posedge clk_in) begin
      if (rst_in || next_state == MS_RUN) begin
         need_manual <= 1'b0;
      end else if (|manual_vec) begin
         need_manual <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         actual_mode_out <= TARGET_RESET;
         zero_power_out <= 1'b0;
      end else begin
         actual_mode_out <= next_actual;
         zero_power_out <= (next_state == MS_SHUT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, read data.

   logic [7:0] rise;
   logic [7:0] next_status;
   logic [7:0] next_active;
   logic status_rd;
   assign next_active = raw & alert_en;
   assign rise = next_active & ~alert_active_out;
   assign status_rd = rd_in && hit(addr_in, REG_STATUS);
   assign next_status = (status_rd ? 8'h00 : irq_status) | rise;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         irq_status <= 8'h00;
         irq_out <= 1'b0;
      end else begin
         irq_status <= next_status;
         irq_out <= |(next_status & irq_mask);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || !rd_in) begin
         rdata_out <= 32'h0000_0000;
      end else begin
         case (addr_in)
            REG_ENABLE: rdata_out <= {24'h000000, alert_en};
            REG_TRIGGER: rdata_out <= {24'h000000, trig_en};
            REG_RECOVERY: rdata_out <= {24'h000000, rec_en};
            REG_TIMEOUT: rdata_out <= {8'h00, tmo_limit};
            REG_KEY: rdata_out <= {24'h000000, alert_key_out};
            REG_TARGET: rdata_out <= {30'h0, target_mode};
            REG_ACTIVE: rdata_out <= {24'h000000, alert_active_out};
            REG_MODE: rdata_out <= {30'h0, actual_mode_out};
            REG_STATUS: rdata_out <= {24'h000000, irq_status};
            REG_MASK: rdata_out <= {24'h000000, irq_mask};
            default: rdata_out <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   AST_TIMEOUT: assert property (@(posedge clk_in) disable iff (rst_in)
      (tmo_cnt > tmo_limit && !setpoint_update_in) |=> ##1 raw[ALT_TIMEOUT])
      else $error("Timeout alert missing after limit passed.");

   AST_ENABLE: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 (alert_active_out & ~$past(alert_en)) == 8'h00)
      else $error("Disabled alert reported active.");

   AST_SHUT_ENTRY: assert property (@(posedge clk_in) disable iff (rst_in)
      (state == MS_RUN && shut_cond) |=>
      (state == MS_SHUT && actual_mode_out == MODE_OOS && zero_power_out))
      else $error("Shutdown not entered on triggered alert.");

   AST_AUTO_RETURN: assert property (@(posedge clk_in) disable iff (rst_in)
      (state == MS_SHUT && !shut_cond && !need_manual) |=>
      (state == MS_RUN && actual_mode_out == $past(target_mode)))
      else $error("Automatic recovery did not return to target.");

   AST_MANUAL_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
      (state == MS_SHUT && need_manual && !host_release) |=> state == MS_SHUT)
      else $error("Manual shutdown left without host release.");

   AST_PERSIST: assert property (@(posedge clk_in) disable iff (rst_in)
      (state == MS_SHUT && shut_cond) |=> (state == MS_SHUT && zero_power_out))
      else $error("Shutdown left while its cause persists.");

   AST_POLARITY: assert property (@(posedge clk_in) disable iff (rst_in)
      (state == MS_RUN && shut_vec[ALT_TRAVEL] && rec_en[ALT_TRAVEL]) |=> need_manual)
      else $error("Travel shutdown with recovery set not held.");

   AST_DEFAULTS: assert property (@(posedge clk_in) disable iff (rst_in)
      (defaults_flag && !leave_oos) |=> defaults_flag)
      else $error("Defaults alert cleared without leaving out of service.");

   AST_KEY: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_in && hit(addr_in, REG_KEY)) |=> alert_key_out == $past(wdata_in[KEY_W-1:0]))
      else $error("Alert key not stored.");

   AST_TRAVEL: assert property (@(posedge clk_in) disable iff (rst_in)
      (oor[0] || disconnect_sync) |=> raw[ALT_TRAVEL])
      else $error("Travel sensor fault not raised.");

   AST_FALLBACK: assert property (@(posedge clk_in) disable iff (rst_in)
      fallback_in && alert_en[ALT_FALLBACK] |=> ##1 alert_active_out[ALT_FALLBACK]
      || !$past(alert_en[ALT_FALLBACK]))
      else $error("Fallback alert missing.");

   CV_SHUT: cover property (@(posedge clk_in) disable iff (rst_in)
      state == MS_RUN ##1 state == MS_SHUT);
   CV_AUTO: cover property (@(posedge clk_in) disable iff (rst_in)
      state == MS_SHUT && !need_manual ##1 state == MS_RUN);
   CV_MANUAL: cover property (@(posedge clk_in) disable iff (rst_in)
      state == MS_SHUT && need_manual && host_release);
   CV_IRQ: cover property (@(posedge clk_in) disable iff (rst_in) irq_out);

endmodule

`default_nettype wire

/* File: csam_pkg.sv */
// Constants shared by the configuration and sensor alert monitor.
// Assumes a single 200 MHz clock and a plain register port.
`default_nettype none

package csam_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Alert bit positions, shared by enable, trigger, recovery and status.
   localparam int NUM_ALERTS = 8;
   localparam int ALT_TIMEOUT = 0;
   localparam int ALT_DEFAULTS = 1;
   localparam int ALT_TRAVEL = 2;
   localparam int ALT_PORT_A = 3;
   localparam int ALT_PORT_B = 4;
   localparam int ALT_SUPPLY = 5;
   localparam int ALT_FALLBACK = 6;
   localparam int ALT_TEMP = 7;
   // Only these alerts may force a shutdown.
   localparam logic [7:0] SHUT_CAPABLE = 8'h0d;
   // For these alerts a set recovery bit means stay out of service.
   localparam logic [7:0] REC_INVERTED = 8'h0c;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses).
   localparam logic [7:0] REG_ENABLE = 8'h00;
   localparam logic [7:0] REG_TRIGGER = 8'h04;
   localparam logic [7:0] REG_RECOVERY = 8'h08;
   localparam logic [7:0] REG_TIMEOUT = 8'h0c;
   localparam logic [7:0] REG_KEY = 8'h10;
   localparam logic [7:0] REG_TARGET = 8'h14;
   localparam logic [7:0] REG_ACTIVE = 8'h18;
   localparam logic [7:0] REG_MODE = 8'h1c;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_MASK = 8'h24;

   ////////////////////////////////////////////////////////////////////////////
   // Field widths and reset values.
   localparam int TMO_W = 24;
   localparam int KEY_W = 8;
   localparam logic [7:0] ENABLE_RESET = 8'hff;
   localparam logic [7:0] TRIGGER_RESET = 8'h00;
   localparam logic [7:0] RECOVERY_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [TMO_W-1:0] TIMEOUT_RESET = 24'h0186a0;
   localparam logic [KEY_W-1:0] KEY_RESET = 8'h00;

   // Transducer block modes.
   localparam logic [1:0] MODE_OOS = 2'h0;
   localparam logic [1:0] MODE_MAN = 2'h1;
   localparam logic [1:0] MODE_AUTO = 2'h2;
   localparam logic [1:0] TARGET_RESET = MODE_AUTO;

   typedef enum logic [0:0] {
      MS_RUN = 1'b0,
      MS_SHUT = 1'b1
   } csam_mstate_t;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: the timeout register counts in ticks of TICK_NS.
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Sensor functional ranges: travel, port A, port B, supply, temperature.
   localparam int NUM_SENSORS = 5;
   localparam logic [15:0] SENS_LO [NUM_SENSORS] = '{16'h0040, 16'h0010,
      16'h0010, 16'h0010, 16'h0020};
   localparam logic [15:0] SENS_HI [NUM_SENSORS] = '{16'hffc0, 16'hfff0,
      16'hfff0, 16'hfff0, 16'hffe0};
   localparam int SENS_ALERT [NUM_SENSORS] = '{ALT_TRAVEL, ALT_PORT_A,
      ALT_PORT_B, ALT_SUPPLY, ALT_TEMP};

endpackage

`default_nettype wire

/* File: csam_sync.sv */
// Two-stage synchroniser for one level from a pin.
// Assumes the level changes slowly compared with the clock.
`timescale 1ns/1ps
`default_nettype none

module csam_sync (
   input wire logic clk_in, // System clock.
   input wire logic rst_in, // Synchronous reset, active high.
   input wire logic async_in, // Level from outside the clock domain.
   output logic sync_out // Level safe to read.
);

   logic meta;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule

`default_nettype wire

/* File: csam_ob_model.sv */
// Output block model: refreshes the monitor's setpoint at a steady interval.
// Assumes the same clock and synchronous reset as the monitor.
`timescale 1ns/1ps
`default_nettype none

module csam_ob_model #(
   parameter int PERIOD = 400
) (
   input wire logic clk_in, // System clock.
   input wire logic rst_in, // Synchronous reset, active high.
   input wire logic run_in, // Block executing; low models a stalled block.
   output logic update_out // One-cycle setpoint update.
);
   int cnt;

   // The period sits well under any timeout the bench sets, so the alert
   // only appears when run_in is dropped on purpose.
   always_ff @(posedge clk_in) begin
      if (rst_in || !run_in) begin
         cnt <= 0;
         update_out <= 1'b0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         update_out <= (cnt == 0);
      end
   end
endmodule

`default_nettype wire

/* File: csam_monitor_tb_top.sv */
// Bench for the alert monitor: register tasks, sensor, mode and timeout tests.
// Assumes the monitor and the output block model share one clock.
`timescale 1ns/1ps
`default_nettype none

module csam_monitor_tb_top;
   import csam_pkg::*;

   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic fb = 1'b0;
   logic disc = 1'b0;
   logic rsd = 1'b0;
   logic run = 1'b0;
   logic [15:0] sens [5] = '{default: 16'h8000};
   logic [31:0] rdata;
   logic [7:0] alerts;
   logic [1:0] mode;
   logic zp;
   logic [7:0] key;
   logic irq;
   logic upd;
   int bad_count = 0;
   int total_checks = 0;
   localparam logic [7:0] RA [11] = '{REG_ENABLE, REG_TRIGGER, REG_RECOVERY,
      REG_TIMEOUT, REG_KEY, REG_TARGET, REG_ACTIVE, REG_MODE, REG_STATUS, REG_MASK, 8'h28};
   localparam logic [31:0] RV [11] = '{32'h0ff, 32'h0, 32'h0, 32'h186a0, 32'h0,
      32'h2, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};

   csam_ob_model csam_ob_model_i (.clk_in(clk_in), .rst_in(rst_in), .run_in(run),
      .update_out(upd));

   csam_monitor csam_monitor_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .setpoint_update_in(upd), .restart_defaults_in(rsd), .fallback_in(fb),
      .travel_disconnect_in(disc), .travel_in(sens[0]), .press_a_in(sens[1]),
      .press_b_in(sens[2]), .supply_in(sens[3]), .temp_in(sens[4]),
      .alert_active_out(alerts), .actual_mode_out(mode), .zero_power_out(zp),
      .alert_key_out(key), .irq_out(irq));

   initial begin
      forever #2.5 clk_in = ~clk_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      chk("rdata", exp, rdata);
   endtask

   task automatic sset(input int i, input logic [15:0] v);
      @(posedge clk_in);
      sens[i] <= v;
   endtask

   task automatic alert_is(input logic [7:0] e);
      cyc(8);
      #1;
      chk("alerts", e, alerts);
   endtask

   task automatic mode_is(input logic [1:0] m, input logic z);
      cyc(8);
      #1;
      chk("mode", m, mode);
      chk("zero_power", z, zp);
   endtask

   task automatic report_and_stop;
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      cyc(16);
      rst_in <= 1'b0;
      run <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         rd_chk(RA[i], RV[i]);
      end
      wr_reg(REG_KEY, 32'h5a);
      rd_chk(REG_KEY, 32'h5a);
      chk("key", 32'h5a, key);
      // Both edges of every range are probed: one step outside must alert.
      for (int i = 0; i < NUM_SENSORS; i++) begin
         sset(i, SENS_LO[i]);
         alert_is(8'h00);
         sset(i, SENS_LO[i] - 16'h1);
         alert_is(8'(1 << SENS_ALERT[i]));
         sset(i, SENS_HI[i] + 16'h1);
         alert_is(8'(1 << SENS_ALERT[i]));
         sset(i, 16'h8000);
         alert_is(8'h00);
      end
      wr_reg(REG_ENABLE, 32'h0ef);
      sset(2, 16'h0);
      alert_is(8'h00);
      sset(2, 16'h8000);
      alert_is(8'h00);
      wr_reg(REG_ENABLE, 32'h0ff);
      @(posedge clk_in);
      fb <= 1'b1;
      alert_is(8'h40);
      @(posedge clk_in);
      fb <= 1'b0;
      disc <= 1'b1;
      alert_is(8'h04);
      @(posedge clk_in);
      disc <= 1'b0;
      alert_is(8'h00);
      rd_chk(REG_STATUS, 32'h0fc);
      rd_chk(REG_STATUS, 32'h0);
      wr_reg(REG_MASK, 32'h080);
      sset(2, 16'h0);
      cyc(8);
      #1;
      chk("irq", 32'h0, irq);
      sset(2, 16'h8000);
      sset(4, 16'hffff);
      cyc(8);
      #1;
      chk("irq", 32'h1, irq);
      sset(4, 16'h8000);
      cyc(8);
      #1;
      chk("irq", 32'h1, irq);
      rd_chk(REG_STATUS, 32'h090);
      cyc(3);
      #1;
      chk("irq", 32'h0, irq);
      wr_reg(REG_MASK, 32'h0);
      wr_reg(REG_TRIGGER, 32'h008);
      sset(1, 16'h0);
      mode_is(MODE_OOS, 1'b1);
      wr_reg(REG_TARGET, 32'h2);
      mode_is(MODE_OOS, 1'b1);
      sset(1, 16'h8000);
      mode_is(MODE_AUTO, 1'b0);
      wr_reg(REG_RECOVERY, 32'h008);
      sset(1, 16'h0);
      mode_is(MODE_OOS, 1'b1);
      sset(1, 16'h8000);
      @(posedge clk_in);
      rsd <= 1'b1;
      @(posedge clk_in);
      rsd <= 1'b0;
      mode_is(MODE_OOS, 1'b1);
      cyc(20);
      alert_is(8'h02);
      wr_reg(REG_TARGET, 32'h1);
      mode_is(MODE_MAN, 1'b0);
      alert_is(8'h00);
      wr_reg(REG_TRIGGER, 32'h004);
      sset(0, 16'h0);
      mode_is(MODE_OOS, 1'b1);
      sset(0, 16'h8000);
      mode_is(MODE_MAN, 1'b0);
      // Five ticks of 200 cycles; strict greater-than needs a sixth tick.
      wr_reg(REG_TIMEOUT, 32'h5);
      wr_reg(REG_TRIGGER, 32'h001);
      wr_reg(REG_RECOVERY, 32'h001);
      // Stop the block just after an update so the silence starts at a known edge.
      n = 0;
      @(posedge clk_in);
      #1;
      while (upd !== 1'b1 && n < 500) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      chk("update_seen", 32'h1, upd);
      @(posedge clk_in);
      run <= 1'b0;
      n = 0;
      while (alerts[0] !== 1'b1 && n < 2000) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      if (n == 2000) begin
         bad_count++;
      end else begin
         chk("timeout_wait", 32'h1,
            32'(n > 5 * TICK_CYCLES && n <= 6 * TICK_CYCLES + 8));
         mode_is(MODE_OOS, 1'b1);
         @(posedge clk_in);
         run <= 1'b1;
         mode_is(MODE_MAN, 1'b0);
         alert_is(8'h00);
         // A held port A shutdown must give way to a reset in mid-run.
         wr_reg(REG_TRIGGER, 32'h008);
         wr_reg(REG_RECOVERY, 32'h008);
         sset(1, 16'h0);
         sset(1, 16'h8000);
         mode_is(MODE_OOS, 1'b1);
         @(posedge clk_in);
         rst_in <= 1'b1;
         cyc(2);
         rst_in <= 1'b0;
         mode_is(MODE_AUTO, 1'b0);
         rd_chk(REG_RECOVERY, 32'h0);
      end
      report_and_stop();
   end
endmodule

`default_nettype wire
